// ---- lbt_consts.svh ----
// Purpose: constants of the loopback and boundary scan test block
// Assumes: 16-bit register words behind a plain strobe port
// Notes:   offsets are register indices; bit positions are word bits
//
// Overview of operation
// [RULE1] internal test modes feed encoder output to decoder; line driver and receiver off
// [RULE2] any loopback test ignores carrier sense when detecting collisions
// [RULE3] twisted pair: duplex and codec bits choose among four loopback or collision tests
// [RULE4] attachment port: loop and codec bits choose internal, external loopback or collision
// [RULE5] collision tests count collisions; sixteen sets the excess collision flag, bit F
// [RULE6] attachment external loopback reports signal quality error, frame still received
// [RULE7] test pin high is normal operation; low holds boundary scan mode
// [RULE8] internal reset applies while the test pin stays low
// [RULE9] in scan mode the address enable input is the shift clock
// [RULE10] entering scan mode floats all digital outputs except the pin a step drives
// [RULE11] tester holds address enable low before lowering the test pin
// [RULE12] output cycle runs first, input cycle second, tester keeps clocking
// [RULE13] output cycle walks a zero over 34 pins, from the link indicator
// [RULE14] input cycle copies 50 selected pin levels to serial ROM data out
// [RULE15] address enable, analog, test and crystal pins are not scanned
// [RULE16] one more clock after the input cycle floats all pins again
// [RULE17] a continuity cycle is 85 clocks and repeats while scanning continues
// [RULE18] test pin high leaves scan mode; address enable regains its bus role
// [RULE19] step counter clears on scan entry and wraps after the 85th clock
// [RULE20] pin order of each scan cycle comes from a configurable table
`ifndef LBT_CONSTS_SVH
`define LBT_CONSTS_SVH
`define LBT_REG_TCTL  8'h19
`define LBT_REG_TXEV  8'h08
`define LBT_REG_SCAN  8'h1a
`define LBT_BIT_FDX   4'he
`define LBT_BIT_AUIL  4'ha
`define LBT_BIT_CODEC 4'h9
`define LBT_BIT_PORT  4'h0
`define LBT_BIT_XCOL  4'hf
`define LBT_COLL_LIM  5'h10
`define LBT_N_OUT     34
`define LBT_N_IN      50
`define LBT_STEP_LAST 7'h54
`define LBT_STEP_IN0  7'h22
`endif

// ---- lbt_pkg.sv ----
// Purpose: types of the loopback and boundary scan test block
// Assumes: included constants header
// Notes:   state of the top module is one packed struct
package lbt_pkg;
  typedef enum logic [2:0] {
    LBT_NORMAL  = 3'b001,
    LBT_SCAN    = 3'b010,
    LBT_BLOCKED = 3'b100
  } lbt_mode_t;

  typedef struct packed {
    lbt_mode_t    mode;
    logic [1:0]   tsync;
    logic [1:0]   async;
    logic         aen_q;
    logic [49:0]  in1;
    logic [49:0]  in2;
    logic [6:0]   step;
    logic [6:0]   act;
    logic         act_valid;
    logic         rom_val;
    logic         full_duplex_select;
    logic         codec;
    logic         aui_loop;
    logic         port_aui;
    logic         xcol;
    logic [4:0]   coll_cnt;
    logic         coll;
    logic         tx_q;
    logic         sqe;
    logic         dec_in;
    logic         core_rst;
    logic         aen_isa;
    logic [15:0]  rdata;
    logic [33:0]  pin_o;
    logic [33:0]  pin_oe;
  } lbt_state_t;

  function automatic logic [299:0] lbt_ident_order(input int n);
    logic [299:0] t;
    t = '0;
    for (int i = 0; i < n; i++) begin
      t[i*6 +: 6] = 6'(i);
    end
    return t;
  endfunction
endpackage

// ---- lbt_test_port.sv ----
// Purpose: loopback mode selection and pin-driven boundary scan
// Assumes: sys_clk 20 MHz; test pin, scan clock and pins are asynchronous
// Notes:   pin index 0 is the link indicator, scan input 0 the sleep input
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "lbt_consts.svh"

module lbt_test_port #(
  parameter logic [299:0] OUT_ORDER   = lbt_pkg::lbt_ident_order(34),
  parameter logic [299:0] IN_ORDER    = lbt_pkg::lbt_ident_order(50),
  parameter logic [5:0]   ROM_OUT_IDX = 6'h01
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        test_n,
  input  wire logic        aen,
  input  wire logic [32:0] scan_in_pins,
  input  wire logic [16:0] bidir_i,
  input  wire logic [16:0] func_out,
  input  wire logic [16:0] func_bidir_o,
  input  wire logic [16:0] func_bidir_oe,
  output logic      [16:0] out_o,
  output logic      [16:0] out_oe,
  output logic      [16:0] bidir_o,
  output logic      [16:0] bidir_oe,
  output logic             core_rst,
  output logic             aen_isa,
  input  wire logic        tx_manchester,
  input  wire logic        rx_line,
  input  wire logic        tx_active,
  input  wire logic        carrier_sense_signal,
  input  wire logic        collision_in,
  output logic             decoder_in,
  output logic             line_tx_en,
  output logic             line_rx_en,
  output logic             collision_detect,
  output logic             sqe_error,
  output logic             excess_collision_flag
);

  // ==========================================================
  // state
  lbt_pkg::lbt_state_t s;
  lbt_pkg::lbt_state_t next_s;

  logic       internal_mode;
  logic       loopback;
  logic       coll_mode;
  logic       ext_aui_loop;
  logic       aen_fall;
  logic [5:0] sel;

  // ==========================================================
  // test mode decode
  always_comb begin
    internal_mode = s.codec; // RULE1
    if (s.port_aui) begin
      loopback     = s.aui_loop; // RULE4
      coll_mode    = !s.aui_loop && !s.codec; // RULE4
      ext_aui_loop = s.aui_loop && !s.codec; // RULE6
    end else begin
      loopback     = s.full_duplex_select; // RULE3
      coll_mode    = !s.full_duplex_select; // RULE3
      ext_aui_loop = 1'b0;
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    sel    = 6'h00;

    // two-flop synchronisers
    next_s.tsync = {s.tsync[0], test_n};
    next_s.async = {s.async[0], aen};
    next_s.in1   = {bidir_i, scan_in_pins};
    next_s.in2   = s.in1;
    next_s.aen_q = s.async[1];
    aen_fall     = s.aen_q && !s.async[1]; // RULE9

    // mode control
    case (s.mode)
      lbt_pkg::LBT_NORMAL: begin
        if (!s.tsync[1]) begin
          if (!s.async[1]) begin
            next_s.mode = lbt_pkg::LBT_SCAN; // RULE7 RULE11
          end else begin
            next_s.mode = lbt_pkg::LBT_BLOCKED; // RULE11
          end
          next_s.step      = 7'h00; // RULE19
          next_s.act_valid = 1'b0;
        end
      end
      lbt_pkg::LBT_SCAN,
      lbt_pkg::LBT_BLOCKED: begin
        if (s.tsync[1]) begin
          next_s.mode      = lbt_pkg::LBT_NORMAL; // RULE18
          next_s.act_valid = 1'b0;
        end
      end
      default: begin
        next_s.mode = lbt_pkg::LBT_NORMAL;
      end
    endcase

    // scan stepping on each falling shift clock edge
    if (s.mode == lbt_pkg::LBT_SCAN && next_s.mode == lbt_pkg::LBT_SCAN && aen_fall) begin
      next_s.act       = s.step; // RULE12
      next_s.act_valid = 1'b1;
      if (s.step == `LBT_STEP_LAST) begin
        next_s.step = 7'h00; // RULE17 RULE19
      end else begin
        next_s.step = s.step + 7'h01;
      end
      if (s.step >= `LBT_STEP_IN0 && s.step < `LBT_STEP_LAST) begin
        sel            = IN_ORDER[(s.step - `LBT_STEP_IN0) * 6 +: 6]; // RULE20
        next_s.rom_val = s.in2[sel]; // RULE14 RULE15
      end
    end

    next_s.core_rst = !s.tsync[1]; // RULE8
    next_s.aen_isa  = (next_s.mode == lbt_pkg::LBT_NORMAL) && s.async[1]; // RULE9 RULE18

    // pin drive
    if (next_s.mode == lbt_pkg::LBT_SCAN) begin
      next_s.pin_o  = '0;
      next_s.pin_oe = '0; // RULE10 RULE16
      if (next_s.act_valid) begin
        if (next_s.act < `LBT_STEP_IN0) begin
          next_s.pin_oe[OUT_ORDER[next_s.act * 6 +: 6]] = 1'b1; // RULE13 RULE20
        end else if (next_s.act < `LBT_STEP_LAST) begin
          next_s.pin_oe[ROM_OUT_IDX] = 1'b1; // RULE14
          next_s.pin_o[ROM_OUT_IDX]  = next_s.rom_val;
        end
      end
    end else if (next_s.mode == lbt_pkg::LBT_BLOCKED) begin
      next_s.pin_o  = '0;
      next_s.pin_oe = '0;
    end else begin
      next_s.pin_o  = {func_bidir_o, func_out};
      next_s.pin_oe = {func_bidir_oe, 17'h1ffff};
    end

    // loopback path and collision detection
    next_s.dec_in = internal_mode ? tx_manchester : rx_line; // RULE1
    next_s.tx_q   = tx_active;
    if (coll_mode) begin
      if (internal_mode) begin
        next_s.coll = tx_active;
      end else begin
        next_s.coll = (tx_active && carrier_sense_signal) || collision_in;
      end
    end else if (loopback) begin
      next_s.coll = 1'b0; // RULE2
    end else begin
      next_s.coll = collision_in;
    end
    next_s.sqe = ext_aui_loop && s.tx_q && !tx_active; // RULE6

    // register port
    next_s.rdata = 16'h0000;
    if (wr) begin
      case (addr)
        `LBT_REG_TCTL: begin
          next_s.full_duplex_select      = wdata[`LBT_BIT_FDX];
          next_s.aui_loop = wdata[`LBT_BIT_AUIL];
          next_s.codec    = wdata[`LBT_BIT_CODEC];
          next_s.port_aui = wdata[`LBT_BIT_PORT];
        end
        `LBT_REG_TXEV: begin
          if (wdata[`LBT_BIT_XCOL]) begin
            next_s.xcol     = 1'b0;
            next_s.coll_cnt = 5'h00;
          end
        end
        default: begin
        end
      endcase
    end
    if (rd) begin
      case (addr)
        `LBT_REG_TCTL: begin
          next_s.rdata[`LBT_BIT_FDX]   = s.full_duplex_select;
          next_s.rdata[`LBT_BIT_AUIL]  = s.aui_loop;
          next_s.rdata[`LBT_BIT_CODEC] = s.codec;
          next_s.rdata[`LBT_BIT_PORT]  = s.port_aui;
        end
        `LBT_REG_TXEV: begin
          next_s.rdata[`LBT_BIT_XCOL] = s.xcol;
        end
        `LBT_REG_SCAN: begin
          next_s.rdata = {s.mode, 6'h00, s.step};
        end
        default: begin
        end
      endcase
    end

    // collision counting; a new event wins over a clear
    if (coll_mode && next_s.coll && !s.coll && s.coll_cnt != `LBT_COLL_LIM) begin
      next_s.coll_cnt = s.coll_cnt + 5'h01; // RULE5
      if (s.coll_cnt + 5'h01 == `LBT_COLL_LIM) begin
        next_s.xcol = 1'b1; // RULE5
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s          <= '0;
      s.mode     <= lbt_pkg::LBT_NORMAL;
      s.tsync    <= 2'h3;
      s.core_rst <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign rdata                 = s.rdata;
  assign out_o                 = s.pin_o[16:0];
  assign out_oe                = s.pin_oe[16:0];
  assign bidir_o               = s.pin_o[33:17];
  assign bidir_oe              = s.pin_oe[33:17];
  assign core_rst              = s.core_rst;
  assign aen_isa               = s.aen_isa;
  assign decoder_in            = s.dec_in;
  assign line_tx_en            = !s.codec; // RULE1
  assign line_rx_en            = !s.codec;
  assign collision_detect      = s.coll;
  assign sqe_error             = s.sqe;
  assign excess_collision_flag = s.xcol;

endmodule
`default_nettype wire

// ---- lbt_tester.sv ----
// Purpose: board tester model that drives the test pin and the scan clock
// Assumes: scan clock period 400 ns, unrelated to the system clock
// Notes:   blk lowers the test pin with the scan clock high
`timescale 1ns/1ns
`default_nettype none
module lbt_tester (
  input  wire logic req,
  input  wire logic blk,
  output logic      test_n,
  output logic      aen
);
  initial begin
    test_n = 1'b1;
    aen    = 1'b0;
    forever begin
      wait (req);
      aen = blk;
      #130 test_n = 1'b0;
      #700;
      while (req) begin
        #200 aen = ~aen;
      end
      aen = 1'b0;
      #70 test_n = 1'b1;
      #500;
    end
  end
endmodule
`default_nettype wire

// ---- lbt_test_port_properties.sv ----
// Purpose: concurrent checks at the test block ports
// Assumes: one sys_clk domain, rst active high
// Notes:   bound to every instance of the block
`timescale 1ns/1ns
`default_nettype none
module lbt_test_port_properties (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        rd,
  input wire logic        wr,
  input wire logic        test_n,
  input wire logic [16:0] out_oe,
  input wire logic [16:0] bidir_o,
  input wire logic [16:0] bidir_oe,
  input wire logic        core_rst,
  input wire logic        aen_isa,
  input wire logic        tx_manchester,
  input wire logic        decoder_in,
  input wire logic        line_tx_en,
  input wire logic        line_rx_en,
  input wire logic [15:0] rdata,
  input wire logic        excess_collision_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // scan pin, reset, loopback and register checks
  sequence s_scan; !test_n [*5]; endsequence
  property p_rst_hold; s_scan |-> core_rst; endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("core reset low in scan");
  property p_aen_off; s_scan |-> !aen_isa; endproperty
  a_aen_off: assert property (p_aen_off) else $error("bus enable live in scan");
  property p_normal; test_n [*6] |-> !core_rst; endproperty
  a_normal: assert property (p_normal) else $error("core reset in normal");
  property p_float; $fell(test_n) |-> ##4 (out_oe == 17'h0) && (bidir_oe == 17'h0); endproperty
  a_float: assert property (p_float) else $error("pins driven on scan entry");
  property p_one_pin; s_scan |-> $countones({bidir_oe, out_oe}) <= 1; endproperty
  a_one_pin: assert property (p_one_pin) else $error("several pins driven");
  property p_walk_low; s_scan |-> (bidir_o & bidir_oe) == 17'h0; endproperty
  a_walk_low: assert property (p_walk_low) else $error("bidir driven high");
  property p_line_off; line_rx_en == line_tx_en; endproperty
  a_line_off: assert property (p_line_off) else $error("line enables differ");
  property p_encdec;
    !line_tx_en && $past(line_tx_en) == 1'b0 |-> decoder_in == $past(tx_manchester);
  endproperty
  a_encdec: assert property (p_encdec) else $error("encoder not looped");
  property p_rd_idle; !$past(rd) |-> rdata == 16'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_xcol;
    $past(excess_collision_flag) && !$past(wr) && test_n |-> excess_collision_flag;
  endproperty
  a_xcol: assert property (p_xcol) else $error("excess flag lost");
endmodule
bind lbt_test_port lbt_test_port_properties u_props (
  .sys_clk(sys_clk), .rst(rst), .rd(rd), .wr(wr), .test_n(test_n), .out_oe(out_oe),
  .bidir_o(bidir_o), .bidir_oe(bidir_oe), .core_rst(core_rst), .aen_isa(aen_isa),
  .tx_manchester(tx_manchester), .decoder_in(decoder_in), .line_tx_en(line_tx_en),
  .line_rx_en(line_rx_en), .rdata(rdata), .excess_collision_flag(excess_collision_flag)
);
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: self-checking bench of the loopback and boundary scan block
// Assumes: 50 ns system clock, 400 ns scan clock from the tester model
// Notes:   identity pin tables, rom output on pin 1
`timescale 1ns/1ns
`default_nettype none
`include "lbt_consts.svh"
module tb_top;
  logic        sys_clk, rst, wr, rd, tx_manchester, rx_line, tx_active, csense, req, blk;
  logic        test_n, aen, core_rst, aen_isa, dec_in, tx_en, rx_en, cdet, sqe, xcol, seen;
  logic        cin;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, v;
  logic [32:0] scan_in;
  logic [49:0] all_in;
  logic [16:0] bid_i, f_out, f_bo, f_boe, out_o, out_oe, bid_o, bid_oe;
  int          fail_count = 0;
  int          checks = 0;
  int          cyc = 0;
  int          s;
  lbt_test_port u_dut (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .test_n(test_n), .aen(aen), .scan_in_pins(scan_in), .bidir_i(bid_i),
    .func_out(f_out), .func_bidir_o(f_bo), .func_bidir_oe(f_boe), .out_o(out_o),
    .out_oe(out_oe), .bidir_o(bid_o), .bidir_oe(bid_oe), .core_rst(core_rst),
    .aen_isa(aen_isa), .tx_manchester(tx_manchester), .rx_line(rx_line),
    .tx_active(tx_active), .carrier_sense_signal(csense), .collision_in(cin),
    .decoder_in(dec_in), .line_tx_en(tx_en), .line_rx_en(rx_en),
    .collision_detect(cdet), .sqe_error(sqe), .excess_collision_flag(xcol)
  );
  lbt_tester u_tester (.req(req), .blk(blk), .test_n(test_n), .aen(aen));
  // ==========================================================
  // tasks
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic final_report;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk((rdata & m) === e, "register read");
    @(posedge sys_clk);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    tx_manchester <= 1'($urandom_range(1));
    rx_line <= 1'($urandom_range(1));
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h86c2));
    {rst, wr, rd, tx_active, csense, cin, req, blk} = 8'h80;
    addr = 8'h00;
    wdata = 16'h0000;
    scan_in = 33'({$urandom, $urandom});
    bid_i = 17'($urandom);
    f_out = 17'($urandom);
    f_bo = 17'($urandom);
    f_boe = 17'($urandom);
    all_in = {bid_i, scan_in};
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd_chk(8'h33, 16'hffff, 16'h0000);
    rd_chk(`LBT_REG_SCAN, 16'he000, 16'h2000);
    v = 16'($urandom) & 16'h4601;
    wr_reg(`LBT_REG_TCTL, v);
    rd_chk(`LBT_REG_TCTL, 16'h4601, v);
    for (int i = 0; i < 16; i++) begin
      wr_reg(`LBT_REG_TCTL, {1'b0, i[2] & !i[3], 3'h0, i[3], i[1], 8'h0, i[3]});
      csense <= i[0];
      tx_active <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 chk(cdet === (!i[3] && !i[2] && (i[1] || i[0])), "collision select");
      chk(tx_en === !i[1] && rx_en === !i[1], "line enables");
      tx_active <= 1'b0;
      @(posedge sys_clk);
    end
    wr_reg(`LBT_REG_TCTL, 16'h0200);
    wr_reg(`LBT_REG_TXEV, 16'h8000);
    for (int n = 1; n <= 16; n++) begin
      tx_active <= 1'b1;
      repeat (2) @(posedge sys_clk);
      tx_active <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 chk(xcol === (n == 16), "excess flag");
    end
    rd_chk(`LBT_REG_TXEV, 16'h8000, 16'h8000);
    wr_reg(`LBT_REG_TXEV, 16'h8000);
    rd_chk(`LBT_REG_TXEV, 16'h8000, 16'h0000);
    wr_reg(`LBT_REG_TCTL, 16'h0401);
    tx_active <= 1'b1;
    repeat (3) @(posedge sys_clk);
    tx_active <= 1'b0;
    seen = 1'b0;
    repeat (4) begin
      @(posedge sys_clk);
      #1 seen = seen | sqe;
    end
    chk(seen === 1'b1 && cdet === 1'b0, "sqe pulse");
    @(posedge sys_clk);
    wr_reg(`LBT_REG_TCTL, 16'h0001);
    cin <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk(cdet === 1'b1, "attachment collision");
    @(posedge sys_clk);
    cin <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk(cdet === 1'b0, "attachment collision end");
    req <= 1'b1;
    wait (!test_n);
    repeat (8) @(posedge sys_clk);
    #1 chk(core_rst === 1'b1 && aen_isa === 1'b0 && {bid_oe, out_oe} === 34'h0, "entry");
    for (int k = 0; k < 90; k++) begin
      s = k % 85;
      @(negedge aen);
      repeat (6) @(posedge sys_clk);
      #1;
      if (s < 34) chk({bid_oe, out_oe} === 34'h1 << s && ({bid_o, out_o} & {bid_oe, out_oe}) === 34'h0, "walk");
      else if (s < 84) chk(out_oe === 17'h2 && bid_oe === 17'h0 && out_o[1] === all_in[s - 34], "echo");
      else chk({bid_oe, out_oe} === 34'h0, "release");
    end
    req <= 1'b0;
    wait (test_n);
    repeat (6) @(posedge sys_clk);
    #1 chk(core_rst === 1'b0 && aen_isa === aen && out_o === f_out, "exit");
    chk(bid_o === f_bo && bid_oe === f_boe && out_oe === 17'h1ffff, "exit pins");
    blk <= 1'b1;
    req <= 1'b1;
    wait (!test_n);
    repeat (40) @(posedge sys_clk);
    #1 chk(core_rst === 1'b1 && {bid_oe, out_oe} === 34'h0, "blocked");
    @(posedge sys_clk);
    rd_chk(`LBT_REG_SCAN, 16'he07f, 16'h8000);
    {blk, req} <= 2'b00;
    wait (test_n);
    repeat (6) @(posedge sys_clk);
    final_report();
  end
endmodule
`default_nettype wire
